// *** design/hpc_pkg.sv ***
// package: register map, field layout and carriers for the host port config
`default_nettype none
package hpc_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [31:0] HPC_OFS_CONFIG   = 32'h4000_0008; // mode and enable
  localparam logic [31:0] HPC_OFS_PAGE_TOP = 32'h4000_000c; // address [31:24]
  localparam logic [31:0] HPC_OFS_PAGE_MID = 32'h4000_0010; // address [23:16]

  // ==========================================================================
  // field positions inside the configuration word
  localparam int HPC_BIT_BYTE_SEL = 4; // host address is a byte address
  localparam int HPC_BIT_FULL_W   = 3; // 32-bit data in multiplexed mode
  localparam int HPC_BIT_SEP      = 2; // separate address and data pins
  localparam int HPC_BIT_PAGE     = 1; // page mode, multiplexed only
  localparam int HPC_BIT_EN       = 0; // port enable
  localparam int HPC_CFG_W        = 5; // implemented configuration bits
  localparam int HPC_PAGE_W       = 8; // width of each page byte
  localparam int HPC_LO_W         = 16; // host supplied low address bits

  // ==========================================================================
  // reset values
  localparam logic [4:0]  HPC_RST_CONFIG = 5'h00;
  localparam logic [7:0]  HPC_RST_PAGE   = 8'h00;
  localparam logic [31:0] HPC_RST_WORD   = 32'h0000_0000;
  localparam logic [15:0] HPC_RST_LO     = 16'h0000;

  // word to byte address conversion: one 32-bit word is four bytes
  localparam int HPC_WORD_SHIFT = 2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic byte_sel;    // addr_type_byte_sel
    logic full_width;  // 32-bit multiplexed data
    logic sep;         // separate_addr_data_en
    logic page;        // page_mode_en
    logic en;          // port_enable_bit
  } hpc_cfg_s;

  typedef struct packed {
    hpc_cfg_s        cfg;  // host_port_config
    logic [7:0]      top;  // page_top_byte
    logic [7:0]      mid;  // page_upper_mid_byte
  } hpc_regs_s;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } hpc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hpc_apb_rsp_s;

endpackage
`default_nettype wire

// *** design/hpc_sync.sv ***
// two-stage synchroniser for the shared host address pins
`default_nettype none
module hpc_sync #(
  parameter int WIDTH = 16  // number of pins brought across
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_sync
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] meta;  // first stage, read only by the second
    logic [WIDTH-1:0] sync;  // second stage, safe for logic
  } hpc_sync_s;

  hpc_sync_s state_reg;  // registered state
  hpc_sync_s state_next; // next state

  // elaboration check: a zero-wide pin group cannot be carried
  if (WIDTH < 1) begin : g_bad_width
    $error("hpc_sync: WIDTH must be at least 1");
  end

  // ==========================================================================
  // next state: shift one stage per enabled clock
  always_comb begin
    state_next = state_reg;
    if (clk_en) begin
      state_next.meta = pins;
      state_next.sync = state_reg.meta;
    end
  end

  // register, constant under reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins_sync = state_reg.sync;

endmodule
`default_nettype wire

// *** design/hpc_addr_form.sv ***
// combinational internal address former for host accesses
`default_nettype none
module hpc_addr_form
  import hpc_pkg::*;
(
  input  wire hpc_pkg::hpc_regs_s regs,      // current configuration
  input  wire logic [31:0]        port_addr, // port address register value
  input  wire logic [15:0]        pin_addr,  // synchronised address pins
  output logic      [31:0]        dsp_addr   // internal byte address
);

  logic [15:0] lo_raw;   // low half before type conversion
  logic [15:0] lo_byte;  // low half as byte offset in the page
  logic [31:0] full_byte; // full address as byte address

  // ==========================================================================
  // pick the source of the low half and convert to bytes
  always_comb begin
    // separate pins carry the low half, else the port address register
    lo_raw = regs.cfg.sep ? pin_addr : port_addr[15:0];
    // word addresses are scaled to bytes; top bits fall off the page
    lo_byte = regs.cfg.byte_sel ? lo_raw
                                : 16'(lo_raw << HPC_WORD_SHIFT);
    full_byte = regs.cfg.byte_sel ? port_addr
                                  : 32'(port_addr << HPC_WORD_SHIFT);
    if (regs.cfg.sep || regs.cfg.page) begin
      // page bytes override the upper half, only software sets them
      dsp_addr = {regs.top, regs.mid, lo_byte};
    end else begin
      // plain multiplexed: host gives the whole address
      dsp_addr = full_byte;
    end
  end

endmodule
`default_nettype wire

// *** design/hpc_top.sv ***
// host port mode, enable and page configuration with its apb register file
//
// Implementation choice: the APB slave port.
`default_nettype none

module hpc_top
  import hpc_pkg::*;
#(
  parameter int SYNC_W = 16  // width of the shared address pins
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  // apb slave
  input  wire hpc_pkg::hpc_apb_req_s apb_req,
  output hpc_pkg::hpc_apb_rsp_s      apb_rsp,
  // host port side, same clock
  input  wire logic                 host_req,
  input  wire logic [31:0]          port_addr,
  // shared pins, asynchronous
  input  wire logic [SYNC_W-1:0]    host_address_inputs,
  // memory interface side
  input  wire logic                 mem_upper_oe_req,
  output logic                      mem_upper_oe,
  // mode outputs to the port
  output logic                      port_enable,
  output logic                      addr_is_byte,
  output logic                      bus_32bit,
  output logic                      separate_mode,
  output logic                      paged_mode,
  // internal access request
  output logic                      dsp_req,
  output logic [31:0]               dsp_addr
);

  // ==========================================================================
  // state
  typedef struct packed {
    hpc_regs_s   regs;     // software visible registers
    logic [31:0] prdata;   // read data captured in setup
    logic        pslverr;  // unmapped address seen in setup
    logic [31:0] dsp_addr; // last formed internal address
    logic        dsp_req;  // one-cycle access request
    logic        mem_oe;   // gated memory upper drive
  } hpc_top_state_s;

  hpc_top_state_s state_reg;  // registered state
  hpc_top_state_s state_next; // next state

  logic [15:0] pins_sync;   // address pins after two flops
  logic [31:0] formed_addr; // combinational internal address
  logic        setup;       // apb setup phase
  logic        access;      // apb access phase, completes this edge
  logic        hit_cfg;     // config register selected
  logic        hit_top;     // top page byte selected
  logic        hit_mid;     // middle page byte selected
  logic        hit_any;     // any mapped register

  // refuse widths the address former cannot take
  if (SYNC_W != HPC_LO_W) begin : g_bad_sync_w
    $error("hpc_top: SYNC_W must be 16");
  end

  // ==========================================================================
  // submodules
  hpc_sync #(
    .WIDTH (SYNC_W)
  ) hpc_sync_inst (
    .clock     (clock),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .pins      (host_address_inputs),
    .pins_sync (pins_sync)
  );

  hpc_addr_form hpc_addr_form_inst (
    .regs      (state_reg.regs),
    .port_addr (port_addr),
    .pin_addr  (pins_sync),
    .dsp_addr  (formed_addr)
  );

  // ==========================================================================
  // apb decode
  always_comb begin
    setup   = apb_req.psel && !apb_req.penable;
    // zero wait: access ends on its first enabled edge
    access  = apb_req.psel && apb_req.penable && clk_en;
    hit_cfg = (apb_req.paddr == HPC_OFS_CONFIG);
    hit_top = (apb_req.paddr == HPC_OFS_PAGE_TOP);
    hit_mid = (apb_req.paddr == HPC_OFS_PAGE_MID);
    hit_any = hit_cfg || hit_top || hit_mid;
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.dsp_req = 1'b0;
    if (clk_en) begin
      // read data and error are prepared in setup so they come from flops
      if (setup) begin
        state_next.pslverr = !hit_any;
        if (hit_cfg) begin
          // reserved bits read as zero
          state_next.prdata = {27'h000_0000, state_reg.regs.cfg};
        end else if (hit_top) begin
          state_next.prdata = {24'h00_0000, state_reg.regs.top};
        end else if (hit_mid) begin
          state_next.prdata = {24'h00_0000, state_reg.regs.mid};
        end else begin
          // unmapped: zero data with error
          state_next.prdata = HPC_RST_WORD;
        end
      end
      // writes land on the completing edge; upper bits are dropped
      if (access && apb_req.pwrite) begin
        if (hit_cfg) begin
          state_next.regs.cfg = apb_req.pwdata[HPC_CFG_W-1:0];
        end else if (hit_top) begin
          state_next.regs.top = apb_req.pwdata[HPC_PAGE_W-1:0];
        end else if (hit_mid) begin
          state_next.regs.mid = apb_req.pwdata[HPC_PAGE_W-1:0];
        end else begin
          // unmapped write is ignored
          state_next.regs = state_reg.regs;
        end
      end
      // host accesses pass only while the port is enabled
      if (host_req && state_reg.regs.cfg.en) begin
        state_next.dsp_req  = 1'b1;
        state_next.dsp_addr = formed_addr;
      end
      // shared pins become inputs in separate mode
      state_next.mem_oe = mem_upper_oe_req
                          && !state_reg.regs.cfg.sep;
    end else begin
      // frozen: the request pulse is held, not repeated
      state_next.dsp_req = state_reg.dsp_req;
    end
  end

  // ==========================================================================
  // state register, constant reset values only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg.regs.cfg <= HPC_RST_CONFIG;
      state_reg.regs.top <= HPC_RST_PAGE;
      state_reg.regs.mid <= HPC_RST_PAGE;
      state_reg.prdata   <= HPC_RST_WORD;
      state_reg.pslverr  <= 1'b0;
      state_reg.dsp_addr <= HPC_RST_WORD;
      state_reg.dsp_req  <= 1'b0;
      state_reg.mem_oe   <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  always_comb begin
    apb_rsp.prdata  = state_reg.prdata;
    apb_rsp.pready  = clk_en;  // stalls the bus while frozen
    apb_rsp.pslverr = state_reg.pslverr && apb_req.psel
                      && apb_req.penable;
  end

  assign port_enable   = state_reg.regs.cfg.en;
  assign addr_is_byte  = state_reg.regs.cfg.byte_sel;
  // separate mode forces 32-bit data, else the width bit decides
  assign bus_32bit     = state_reg.regs.cfg.sep
                         || state_reg.regs.cfg.full_width;
  assign separate_mode = state_reg.regs.cfg.sep;
  // page mode has no meaning with separate pins
  assign paged_mode    = state_reg.regs.cfg.page
                         && !state_reg.regs.cfg.sep;
  assign mem_upper_oe  = state_reg.mem_oe;
  assign dsp_req       = state_reg.dsp_req;
  assign dsp_addr      = state_reg.dsp_addr;

  // ==========================================================================
  // assertions
  property p_word_addr_scaled;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable && !addr_is_byte
       && !separate_mode && !state_reg.regs.cfg.page)
      |=> dsp_addr == 32'($past(port_addr) << 2);
  endproperty
  a_word_addr_scaled: assert property (p_word_addr_scaled)
    else $error("word address not scaled to bytes");

  property p_width_select;
    @(posedge clock) disable iff (!rstn)
      !separate_mode |-> bus_32bit == state_reg.regs.cfg.full_width;
  endproperty
  a_width_select: assert property (p_width_select)
    else $error("multiplexed width does not follow width bit");

  property p_sep_full_bus;
    @(posedge clock) disable iff (!rstn)
      separate_mode |-> bus_32bit && !paged_mode;
  endproperty
  a_sep_full_bus: assert property (p_sep_full_bus)
    else $error("separate mode not on a 32-bit bus");

  property p_mem_inhibit;
    @(posedge clock) disable iff (!rstn)
      (clk_en && separate_mode) |=> !mem_upper_oe;
  endproperty
  a_mem_inhibit: assert property (p_mem_inhibit)
    else $error("memory bus drives shared pins in separate mode");

  property p_full_addr;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable && addr_is_byte
       && !separate_mode && !state_reg.regs.cfg.page)
      |=> dsp_req && dsp_addr == $past(port_addr);
  endproperty
  a_full_addr: assert property (p_full_addr)
    else $error("unpaged multiplexed address not passed whole");

  property p_paged_low;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable && addr_is_byte && paged_mode)
      |=> dsp_addr[15:0] == $past(port_addr[15:0]);
  endproperty
  a_paged_low: assert property (p_paged_low)
    else $error("paged low half not from host");

  property p_disabled_quiet;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !port_enable) |=> !dsp_req;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("access passed while port disabled");

  property p_top_byte;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable && (separate_mode || paged_mode))
      |=> dsp_addr[31:24] == $past(state_reg.regs.top);
  endproperty
  a_top_byte: assert property (p_top_byte)
    else $error("top page byte not on bits 31:24");

  property p_mid_byte;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable && (separate_mode || paged_mode))
      |=> dsp_addr[23:16] == $past(state_reg.regs.mid);
  endproperty
  a_mid_byte: assert property (p_mid_byte)
    else $error("middle page byte not on bits 23:16");

  property p_sep_pins;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable && separate_mode && addr_is_byte)
      |=> dsp_addr[15:0] == $past(pins_sync);
  endproperty
  a_sep_pins: assert property (p_sep_pins)
    else $error("separate mode low half not from pins");

  property p_page_write;
    @(posedge clock) disable iff (!rstn)
      (access && apb_req.pwrite && hit_top)
      |=> state_reg.regs.top == $past(apb_req.pwdata[7:0]);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("top page byte write lost");

  // register file: writes land whole, reads return the stored bits
  property p_cfg_write;
    @(posedge clock) disable iff (!rstn)
      (access && apb_req.pwrite && hit_cfg)
      |=> state_reg.regs.cfg == $past(apb_req.pwdata[4:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write lost");

  property p_mid_write;
    @(posedge clock) disable iff (!rstn)
      (access && apb_req.pwrite && hit_mid)
      |=> state_reg.regs.mid == $past(apb_req.pwdata[7:0]);
  endproperty
  a_mid_write: assert property (p_mid_write)
    else $error("middle page byte write lost");

  property p_cfg_read;
    @(posedge clock) disable iff (!rstn)
      (access && !apb_req.pwrite && hit_cfg)
      |-> apb_rsp.prdata == {27'h000_0000, state_reg.regs.cfg};
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("configuration read back wrong");

  property p_unmapped_err;
    @(posedge clock) disable iff (!rstn)
      (access && !hit_any) |-> apb_rsp.pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access without error");

  // host requests: one pulse per accepted request, address held between
  property p_enabled_pass;
    @(posedge clock) disable iff (!rstn)
      (clk_en && host_req && port_enable) |=> dsp_req;
  endproperty
  a_enabled_pass: assert property (p_enabled_pass)
    else $error("enabled host access not passed");

  property p_req_one_cycle;
    @(posedge clock) disable iff (!rstn)
      (clk_en && dsp_req && !(host_req && port_enable)) |=> !dsp_req;
  endproperty
  a_req_one_cycle: assert property (p_req_one_cycle)
    else $error("internal request longer than one cycle");

  property p_addr_hold;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !(host_req && port_enable)) |=> $stable(dsp_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("internal address moved without a request");

  property p_mem_pass;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !separate_mode)
      |=> mem_upper_oe == $past(mem_upper_oe_req);
  endproperty
  a_mem_pass: assert property (p_mem_pass)
    else $error("memory drive not passed in multiplexed mode");

  // a low enable must freeze every register of the block
  property p_frozen;
    @(posedge clock) disable iff (!rstn)
      !clk_en |=> $stable(state_reg);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state changed while clock enable low");

endmodule
`default_nettype wire

// *** dv/hpc_host_model.sv ***
// behavioural model of the host side port logic and its address pins
`default_nettype none
module hpc_host_model (
  input  wire logic        clock,
  output logic             host_req,
  output logic      [31:0] port_addr,
  output logic      [15:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle values at time zero
  initial begin
    host_req  = 1'b0;
    port_addr = 32'h0000_0000;
    pins      = 16'h0000;
  end

  // ==========================================================================
  // one access: address register is set together with the request
  task automatic access(input logic [31:0] a);
    @(posedge clock);
    host_req  <= 1'b1;
    port_addr <= a;
    @(posedge clock);
    host_req  <= 1'b0;
    // released value is inverted so a stale sample cannot pass
    port_addr <= ~a;
  endtask

  // two accesses on consecutive edges, no idle cycle between
  task automatic burst(input logic [31:0] a, input logic [31:0] b);
    @(posedge clock);
    host_req  <= 1'b1;
    port_addr <= a;
    @(posedge clock);
    port_addr <= b;
    @(posedge clock);
    host_req  <= 1'b0;
    port_addr <= ~b;
  endtask

  // separate mode: host drives the shared address pins
  task automatic set_pins(input logic [15:0] v);
    @(posedge clock);
    pins <= v;
  endtask
endmodule
`default_nettype wire

// *** dv/host_port_mode_and_page_config_tb_top.sv ***
// self-checking testbench for the host port mode and page block
`default_nettype none
module host_port_mode_and_page_config_tb_top
  import hpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals
  logic         clock, rstn, clk_en, mem_upper_oe_req;
  hpc_apb_req_s apb_req;
  hpc_apb_rsp_s apb_rsp;
  logic         host_req;
  logic  [31:0] port_addr;
  logic  [15:0] pins;
  logic         mem_upper_oe, port_enable, addr_is_byte, bus_32bit;
  logic         separate_mode, paged_mode, dsp_req;
  logic  [31:0] dsp_addr;
  logic   [4:0] cfg;              // last configuration written
  logic   [7:0] pg_top, pg_mid;   // last page bytes written
  int           error_cnt, checks, cyc;

  hpc_top hpc_top_inst (.clock(clock), .rstn(rstn), .clk_en(clk_en),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .host_req(host_req),
    .port_addr(port_addr), .host_address_inputs(pins),
    .mem_upper_oe_req(mem_upper_oe_req), .mem_upper_oe(mem_upper_oe),
    .port_enable(port_enable), .addr_is_byte(addr_is_byte),
    .bus_32bit(bus_32bit), .separate_mode(separate_mode),
    .paged_mode(paged_mode), .dsp_req(dsp_req), .dsp_addr(dsp_addr));

  hpc_host_model hpc_host_model_inst (.clock(clock), .host_req(host_req),
    .port_addr(port_addr), .pins(pins));

  // ==========================================================================
  // clock, and a cycle ceiling so a hang still ends in the report
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end

  // ==========================================================================
  // reporting
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] g, e, input string w);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic cmp_bit(input logic g, e, input string w);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t %s got %b exp %b", $time, w, g, e);
    end
  endtask

  // ==========================================================================
  // apb master: hold everything until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    apb_req.paddr   <= a;
    apb_req.pwrite  <= wr;
    apb_req.pwdata  <= d;
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    @(posedge clock);
    apb_req.penable <= 1'b1;
    @(posedge clock);
    while (apb_rsp.pready !== 1'b1) @(posedge clock);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, e, input logic ee);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    cmp_word(rd, e, "read data");
    cmp_bit(err, ee, "read slverr");
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  // mode bits first, enable last
  task automatic set_cfg(input logic [4:0] c);
    wr(HPC_OFS_CONFIG, {27'h0, c[4:1], 1'b0});
    wr(HPC_OFS_CONFIG, {27'h0, c});
    cfg = c;
  endtask

  // internal address expected from mode, page bytes and host address
  function automatic logic [31:0] exp_addr(input logic [4:0] c,
                                           input logic [31:0] a);
    logic [15:0] lo;
    lo = c[2] ? pins : a[15:0];
    if (!c[4]) lo = lo << 2;
    if (c[2] | c[1]) return {pg_top, pg_mid, lo};
    return c[4] ? a : a << 2;
  endfunction

  task automatic host_chk(input logic [31:0] a, input logic en);
    logic [31:0] prev;
    prev = dsp_addr;
    hpc_host_model_inst.access(a);
    #1;
    cmp_bit(dsp_req, en, "dsp_req");
    cmp_word(dsp_addr, en ? exp_addr(cfg, a) : prev, "dsp_addr");
    @(posedge clock);
    #1;
    cmp_bit(dsp_req, 1'b0, "dsp_req pulse");
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rd_chk(HPC_OFS_CONFIG, 32'h0000_0000, 1'b0);
    rd_chk(HPC_OFS_PAGE_TOP, 32'h0000_0000, 1'b0);
    rd_chk(HPC_OFS_PAGE_MID, 32'h0000_0000, 1'b0);
    cmp_bit(port_enable, 1'b0, "enable after reset");
  endtask

  task automatic t_regs();
    wr(HPC_OFS_PAGE_TOP, 32'h0000_00a5);
    wr(HPC_OFS_PAGE_MID, 32'h0000_003c);
    pg_top = 8'ha5;
    pg_mid = 8'h3c;
    rd_chk(HPC_OFS_PAGE_TOP, 32'h0000_00a5, 1'b0);
    rd_chk(HPC_OFS_PAGE_MID, 32'h0000_003c, 1'b0);
    wr(32'h4000_0014, 32'h0000_0001);
    rd_chk(32'h4000_0014, 32'h0000_0000, 1'b1);
    rd_chk(HPC_OFS_CONFIG, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_modes();
    for (int i = 0; i < 16; i++) begin
      set_cfg({i[3:0], 1'b1});
      rd_chk(HPC_OFS_CONFIG, {27'h0, cfg}, 1'b0);
      cmp_bit(addr_is_byte, cfg[4], "byte type");
      cmp_bit(bus_32bit, cfg[3] | cfg[2], "width");
      cmp_bit(separate_mode, cfg[2], "separate");
      cmp_bit(paged_mode, cfg[1] & !cfg[2], "paged");
      cmp_bit(port_enable, 1'b1, "enable");
    end
  endtask

  task automatic t_addr();
    logic [4:0] modes [7] = '{5'h01, 5'h11, 5'h03, 5'h13, 5'h05, 5'h15,
                              5'h07};
    hpc_host_model_inst.set_pins(16'h9c3b);
    for (int i = 0; i < 7; i++) begin
      set_cfg(modes[i]);
      repeat (3) @(posedge clock);
      host_chk(32'hc1f3_8a67 + i, 1'b1);
    end
    set_cfg(5'h03);
    hpc_host_model_inst.burst(32'h0000_fffe, 32'h0123_4001);
    #1;
    cmp_bit(dsp_req, 1'b1, "second of pair");
    cmp_word(dsp_addr, {8'ha5, 8'h3c, 16'h0004}, "second addr");
  endtask

  task automatic t_disabled();
    set_cfg(5'h00);
    host_chk(32'h5555_aaaa, 1'b0);
    set_cfg(5'h01);
    clk_en <= 1'b0;
    host_chk(32'h1111_2222, 1'b0);
    cmp_bit(apb_rsp.pready, 1'b0, "pready while frozen");
    clk_en <= 1'b1;
  endtask

  task automatic t_mem_oe();
    set_cfg(5'h00);
    mem_upper_oe_req <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    cmp_bit(mem_upper_oe, 1'b1, "memory drive allowed");
    set_cfg(5'h04);
    repeat (2) @(posedge clock);
    #1;
    cmp_bit(mem_upper_oe, 1'b0, "memory drive blocked");
    mem_upper_oe_req <= 1'b0;
  endtask

  // reset again in mid-run: every register must fall back to zero
  task automatic t_rerun();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    cmp_bit(separate_mode, 1'b0, "separate after reset");
    t_reset();
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rstn             = 1'b0;
    clk_en           = 1'b1;
    mem_upper_oe_req = 1'b0;
    apb_req          = '0;
    cfg              = 5'h00;
    pg_top           = 8'h00;
    pg_mid           = 8'h00;
    error_cnt        = 0;
    checks           = 0;
    cyc              = 0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_modes();
    t_addr();
    t_disabled();
    t_mem_oe();
    t_rerun();
    close_out();
  end
endmodule
`default_nettype wire
